// File: rtl/dsr_pkg.sv
// Package for the debug status register block: map, fields, resets, timing
package dsr_pkg;
   // Register location in the debug map
   localparam logic [15:0] DSR_ADDR        = 16'hFF01;
   // Field positions
   localparam int          DSR_BIT_ENABLE  = 7;
   localparam int          DSR_BIT_ACTIVE  = 6;
   localparam int          DSR_BIT_TAG     = 5;
   localparam int          DSR_BIT_SDV     = 4;
   localparam int          DSR_BIT_STEP    = 3;
   localparam int          DSR_BIT_CLKSEL  = 2;
   localparam int          DSR_BIT_UNSECURE_FLAG   = 1;
   // Value after reset (all flags clear)
   localparam logic [7:0]  DSR_RESET       = 8'h00;
   // Tag arming delay in debug cycles
   localparam int          DSR_TAG_CYCLES  = 16;
   localparam logic [4:0]  DSR_TAG_CNT     = 5'(DSR_TAG_CYCLES);
   // Clock switch settling time in debug cycles
   localparam int          DSR_CLK_CYCLES  = 150;
   localparam logic [7:0]  DSR_CLK_CNT     = 8'(DSR_CLK_CYCLES);

   // Source of a register write
   typedef enum logic [1:0] {
      DSR_SRC_HW,          // Debug hardware write command
      DSR_SRC_FW,          // Standard debug firmware store
      DSR_SRC_SECFW,       // Secure debug firmware store
      DSR_SRC_OTHER        // Any other master
   } dsr_src_e;

   // Register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
      dsr_src_e    src;
      logic        exit_store;  // Timed firmware exit store
   } dsr_req_s;

   // Command-side events from the serial engine
   typedef struct packed {
      logic enter;        // Debug mode entered
      logic tag_go;       // Tag-go command executed
      logic cmd_rcvd;     // Any command recognized
      logic cmd_step;     // Recognized command is single step
      logic fw_rd_done;   // Firmware read data sent
      logic fw_wr_done;   // Firmware write data received
   } dsr_evt_s;
endpackage

// File: rtl/dsr_delay.sv
// Countdown delay used for tag arming and clock switch settling
`timescale 1ns/1ps
module dsr_delay #(
   parameter int W = 8
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_start,    // Restart the countdown
   input  wire logic [W-1:0] i_count,    // Cycles to wait
   output logic              o_busy,     // Counting
   output logic              o_done      // One-cycle pulse at the end
);
   logic [W-1:0] cnt_r;                  // Remaining cycles

   // Load on start, count down to zero, pulse on the last step
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         cnt_r  <= '0;
         o_done <= 1'b0;
      end else if (i_start) begin
         cnt_r  <= i_count;
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt_r == W'(1));
         if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end

   assign o_busy = (cnt_r != '0);
endmodule

// File: rtl/dsr_status.sv
// Debug status register with its flags, write guards and secure read view
//
// What this block does
// - Enable bit gates active entry; hardware commands unaffected
// - Special mode: enable set after reset, unless secured without a finished, passed erase
// - Only hardware sets active flag on entry
// - Only firmware exit store clears active flag
// - Tag flag set by tag-go, cleared on entry
// - Serial off, tagging on, 16 cycles later
// - Shift-valid set after firmware data phase
// - Shift-valid cleared on next command or exit
// - Step flag follows back-to-back single-step commands
// - Clock select written only by debug writes
// - Register at 0xFF01, readable in all modes
// - Special mode enable reads one when permitted
// - Special mode unsecure reads one when secured-erased
// - Clock select takes effect after 150 cycles
// - Unsecure writable by secure firmware in special mode only, resets zero
`timescale 1ns/1ps
module dsr_status
   import dsr_pkg::*;
(
   input  wire logic            i_sys_clk,
   input  wire logic            i_reset_n,
   input  wire dsr_pkg::dsr_req_s i_req,        // Register access
   input  wire dsr_pkg::dsr_evt_s i_evt,        // Serial engine events
   input  wire logic            i_enter_req,    // Request to go active
   input  wire logic            i_special_mode, // Special single-chip mode
   input  wire logic            i_secured,      // Part is secured
   input  wire logic            i_erase_ok,     // Erase verify passed
   input  wire logic            i_erase_done,   // Erase verify finished
   output logic [7:0]           o_rdata,        // Read data
   output logic                 o_rvalid,       // Read data valid pulse
   output logic                 o_enter_ok,     // Entry may proceed
   output logic                 o_fw_map,       // Firmware table mapped
   output logic                 o_serial_en,    // Serial commands allowed
   output logic                 o_tag_active,   // Instruction tagging on
   output logic                 o_clk_sel,      // Clock select in effect
   output logic                 o_clk_busy      // Clock switch settling
);
   import dsr_pkg::*;

   logic       enable_r;        // Debug enable flag
   logic       active_r;        // Debug active flag
   logic       tag_r;           // Tagging enable flag
   logic       sdv_r;           // Shift data valid flag
   logic       step_r;          // Single-step flag
   logic       clksel_r;        // Clock select as written
   logic       clksel_eff_r;    // Clock select after settling
   logic       unsecure_flag_r;         // Unsecure flag
   logic       boot_r;          // Special-mode enable still pending
   logic       tag_armed_r;     // Tagging running, serial off
   logic       hit;             // Access addresses this register
   logic       dbg_wr;          // Write from hardware or firmware
   logic       tag_done;        // Tag arming delay finished
   logic       clk_done;        // Clock settle finished
   logic       tag_start;       // Tag flag written to one
   logic       clk_start;       // Clock select changed
   logic       exit_clr;        // Firmware exit clears active
   logic [7:0] status;          // Assembled register image

   assign hit    = (i_req.addr == DSR_ADDR);
   assign dbg_wr = hit && i_req.wr &&
                   (i_req.src == DSR_SRC_HW || i_req.src == DSR_SRC_FW);
   assign exit_clr = hit && i_req.wr && i_req.src == DSR_SRC_FW &&
                     i_req.exit_store &&
                     !i_req.wdata[DSR_BIT_ACTIVE];

   // Enable flag; boot pending until secure checks allow the set
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         enable_r <= 1'b0;
         boot_r   <= 1'b1;
      end else if (boot_r && i_special_mode &&
                   (!i_secured || (i_erase_done && i_erase_ok))) begin
         enable_r <= 1'b1;
         boot_r   <= 1'b0;
      end else if (dbg_wr) begin
         enable_r <= i_req.wdata[DSR_BIT_ENABLE];
         if (!i_special_mode || !i_secured || i_erase_done) begin
            boot_r <= 1'b0;           // Stop waiting once decided
         end
      end else if (!i_special_mode || (i_secured && i_erase_done)) begin
         boot_r <= 1'b0;              // Failed erase leaves flag clear
      end
   end

   // Entry is refused while disabled; hardware commands run regardless
   assign o_enter_ok = i_enter_req && enable_r && !active_r;

   // Active flag: set by entry only, cleared by the exit store only
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         active_r <= 1'b0;
      end else if (o_enter_ok || i_evt.enter) begin
         active_r <= 1'b1;
      end else if (exit_clr) begin
         active_r <= 1'b0;
      end
   end
   assign o_fw_map = active_r;

   // Tagging flag: entry clears, tag-go or a write sets
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         tag_r <= 1'b0;
      end else if (o_enter_ok || i_evt.enter) begin
         tag_r <= 1'b0;
      end else if (i_evt.tag_go) begin
         tag_r <= 1'b1;
      end else if (dbg_wr) begin
         tag_r <= i_req.wdata[DSR_BIT_TAG];
      end
   end

   assign tag_start = i_evt.tag_go ||
                      (dbg_wr && i_req.wdata[DSR_BIT_TAG]);

   // Arming delay so the tag-go answer can finish on the wire
   dsr_delay #(.W(5)) u_tag_delay (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_start   (tag_start),
      .i_count   (DSR_TAG_CNT),
      .o_busy    (),
      .o_done    (tag_done)
   );

   // Tagging runs until the flag drops (entry through a tag hit)
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         tag_armed_r <= 1'b0;
      end else if (!tag_r) begin
         tag_armed_r <= 1'b0;
      end else if (tag_done) begin
         tag_armed_r <= 1'b1;
      end
   end
   assign o_tag_active = tag_armed_r;
   assign o_serial_en  = !tag_armed_r;

   // Shift-valid: set wins over clear so a finished phase is not lost
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         sdv_r <= 1'b0;
      end else if (i_evt.fw_rd_done || i_evt.fw_wr_done) begin
         sdv_r <= 1'b1;
      end else if (i_evt.cmd_rcvd || exit_clr) begin
         sdv_r <= 1'b0;
      end else if (dbg_wr) begin
         sdv_r <= i_req.wdata[DSR_BIT_SDV];
      end
   end

   // Single-step flag follows the kind of each recognized command
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         step_r <= 1'b0;
      end else if (i_evt.cmd_rcvd) begin
         step_r <= i_evt.cmd_step;
      end else if (dbg_wr) begin
         step_r <= i_req.wdata[DSR_BIT_STEP];
      end
   end

   // Clock select accepts debug writes only; other masters ignored
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         clksel_r <= 1'b0;
      end else if (dbg_wr) begin
         clksel_r <= i_req.wdata[DSR_BIT_CLKSEL];
      end
   end

   assign clk_start = dbg_wr &&
                      (i_req.wdata[DSR_BIT_CLKSEL] != clksel_r);

   // Settling delay before the new clock is guaranteed
   dsr_delay #(.W(8)) u_clk_delay (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_start   (clk_start),
      .i_count   (DSR_CLK_CNT),
      .o_busy    (o_clk_busy),
      .o_done    (clk_done)
   );

   // Effective select moves only after the settling time
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         clksel_eff_r <= 1'b0;
      end else if (clk_done) begin
         clksel_eff_r <= clksel_r;
      end
   end
   assign o_clk_sel = clksel_eff_r;

   // Unsecure: secure firmware in special mode only
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         unsecure_flag_r <= 1'b0;
      end else if (hit && i_req.wr && i_req.src == DSR_SRC_SECFW &&
                   i_special_mode) begin
         unsecure_flag_r <= i_req.wdata[DSR_BIT_UNSECURE_FLAG];
      end
   end

   // Read image; secure special mode shows erase outcome
   always_comb begin
      status                 = DSR_RESET;   // Bit 0 stays zero
      status[DSR_BIT_ENABLE] = enable_r;
      status[DSR_BIT_ACTIVE] = active_r;
      status[DSR_BIT_TAG]    = tag_r;
      status[DSR_BIT_SDV]    = sdv_r;
      status[DSR_BIT_STEP]   = step_r;
      status[DSR_BIT_CLKSEL] = clksel_r;
      status[DSR_BIT_UNSECURE_FLAG]  = unsecure_flag_r;
      if (i_special_mode) begin
         status[DSR_BIT_ENABLE] = enable_r &&
                                  (!i_secured || i_erase_ok);
         status[DSR_BIT_UNSECURE_FLAG]  = i_secured && i_erase_ok;
      end
   end

   // Registered read data, any source, any mode
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= hit && i_req.rd;
         if (hit && i_req.rd) begin
            o_rdata <= status;
         end
      end
   end
endmodule

// File: dv/dsr_host_model.sv
// Host debugger model that issues single-byte status register commands
`timescale 1ns/1ps
module dsr_host_model
   import dsr_pkg::*;
(
   input  wire logic         i_sys_clk,
   output dsr_pkg::dsr_req_s o_req      // Command toward the register
);
   // Quiet bus at time zero
   initial o_req = '0;

   // One command, held over exactly one sampling edge; afterwards the
   // released address and data show their inverse, never a stale value
   task automatic cmd(input logic w, input logic [7:0] d,
                      input dsr_src_e s, input logic x);
      @(negedge i_sys_clk);
      o_req = '{w, !w, DSR_ADDR, d, s, x};
      @(negedge i_sys_clk);
      o_req = '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata, o_req.src, 1'b0};
   endtask
endmodule

// File: dv/dsr_status_monitor.sv
// Concurrent checks on the ports of the debug status register
`timescale 1ns/1ps
module dsr_status_monitor
   import dsr_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset_n,
   input  wire dsr_pkg::dsr_req_s i_req,
   input  wire dsr_pkg::dsr_evt_s i_evt,
   input  wire logic              i_enter_req,
   input  wire logic [7:0]        o_rdata,
   input  wire logic              o_rvalid,
   input  wire logic              o_enter_ok,
   input  wire logic              o_fw_map,
   input  wire logic              o_serial_en,
   input  wire logic              o_tag_active,
   input  wire logic              o_clk_sel,
   input  wire logic              o_clk_busy
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Request aimed at this register
   logic hit;
   assign hit = (i_req.addr == DSR_ADDR);
   // Tag arming write while the serial side is still live
   sequence s_tag_wr;
      i_req.wr && hit && i_req.wdata[5]
         && i_req.src inside {DSR_SRC_HW, DSR_SRC_FW}
         && o_serial_en && !o_tag_active;
   endsequence
   // Permitted write that changes the clock select
   sequence s_clk_wr;
      i_req.wr && hit && i_req.src inside {DSR_SRC_HW, DSR_SRC_FW}
         && i_req.wdata[2] != o_clk_sel && !o_clk_busy;
   endsequence

   a_enter_gate: assert property (
      o_enter_ok |-> i_enter_req && !o_fw_map)
      else $error("entry granted without request or while active");
   a_active_set: assert property (
      $rose(o_fw_map) |-> $past(o_enter_ok || i_evt.enter))
      else $error("active flag rose without an entry");
   a_active_clr: assert property (
      $fell(o_fw_map) |-> $past(i_req.wr && hit && i_req.exit_store
         && i_req.src == DSR_SRC_FW && !i_req.wdata[6]))
      else $error("active flag cleared without firmware exit store");
   a_tag_delay: assert property (
      s_tag_wr |-> ##1 !o_tag_active [*8] ##9 !o_tag_active
         ##1 o_tag_active && !o_serial_en)
      else $error("tagging not armed on time");
   a_serial_off: assert property (
      o_tag_active |-> !o_serial_en)
      else $error("serial commands open while tagging");
   a_clk_settle: assert property (
      s_clk_wr |-> ##2 o_clk_busy [*8] ##140 o_clk_busy ##1 o_clk_busy
         ##1 !o_clk_busy)
      else $error("clock switch settling time wrong");
   a_clk_refuse: assert property (
      i_req.wr && hit && i_req.src == DSR_SRC_OTHER && !o_clk_busy
         |=> !o_clk_busy [*3])
      else $error("clock switch started by a foreign write");
   a_read_answer: assert property (
      i_req.rd && hit |=> o_rvalid && !o_rdata[0])
      else $error("read answer missing or bit zero set");
endmodule

bind dsr_status dsr_status_monitor u_mon (.i_sys_clk(i_sys_clk),
   .i_reset_n(i_reset_n), .i_req(i_req), .i_evt(i_evt),
   .i_enter_req(i_enter_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .o_enter_ok(o_enter_ok), .o_fw_map(o_fw_map),
   .o_serial_en(o_serial_en), .o_tag_active(o_tag_active),
   .o_clk_sel(o_clk_sel), .o_clk_busy(o_clk_busy));

// File: dv/dsr_status_tb_top.sv
// Self-checking bench for the debug status register
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
   n_fail++; $display("wrong value %s expected %h seen %h", nm, exp, got); \
   end end
module dsr_status_tb_top;
   import dsr_pkg::*;
   logic       i_sys_clk, i_reset_n, i_enter_req, i_special_mode;
   logic       i_secured, i_erase_ok, i_erase_done;
   dsr_req_s   i_req;          // Driven by the host model
   dsr_evt_s   i_evt;          // Serial engine event pulses
   logic [7:0] o_rdata;
   logic       o_rvalid, o_enter_ok, o_fw_map, o_serial_en;
   logic       o_tag_active, o_clk_sel, o_clk_busy;
   int         n_fail, check_count;

   // 250 MHz system clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   dsr_host_model host (.i_sys_clk(i_sys_clk), .o_req(i_req));
   dsr_status dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_req(i_req), .i_evt(i_evt), .i_enter_req(i_enter_req),
      .i_special_mode(i_special_mode), .i_secured(i_secured),
      .i_erase_ok(i_erase_ok), .i_erase_done(i_erase_done),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_enter_ok(o_enter_ok),
      .o_fw_map(o_fw_map), .o_serial_en(o_serial_en),
      .o_tag_active(o_tag_active), .o_clk_sel(o_clk_sel),
      .o_clk_busy(o_clk_busy));

   // Verdict and end of run
   task automatic test_done();
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Read the register and compare the answer
   task automatic rd_chk(input logic [7:0] exp);
      host.cmd(1'b0, 8'h00, DSR_SRC_HW, 1'b0);
      `CHK("rvalid", 1'b1, o_rvalid)
      `CHK("rdata", exp, o_rdata)
   endtask
   // One-cycle event pulse; six bits, one per event flag
   task automatic ev(input logic [5:0] e);
      @(negedge i_sys_clk);
      i_evt = dsr_evt_s'(e);
      @(negedge i_sys_clk);
      i_evt = '0;
   endtask
   // Drive a level on the entry request and sample the grant
   task automatic enter(input logic exp);
      @(negedge i_sys_clk);
      i_enter_req = 1'b1;
      #1 `CHK("enter_ok", exp, o_enter_ok)
      @(negedge i_sys_clk);
      i_enter_req = 1'b0;
      `CHK("fw_map", exp, o_fw_map)
   endtask

   // Guard against a hang
   initial begin
      repeat (3000) @(posedge i_sys_clk);
      n_fail++;
      test_done();
   end

   // Main sequence; special mode, secured but fully erased, at boot
   initial begin
      {i_reset_n, i_enter_req, i_evt} = '0;
      {i_special_mode, i_secured, i_erase_ok, i_erase_done} = 4'hF;
      n_fail = 0;
      check_count = 0;
      repeat (2) @(negedge i_sys_clk);
      i_reset_n = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      rd_chk(8'h82);
      i_special_mode = 1'b0;
      host.cmd(1'b1, 8'h03, DSR_SRC_HW, 1'b0);
      rd_chk(8'h00);
      enter(1'b0);
      host.cmd(1'b1, 8'h80, DSR_SRC_HW, 1'b0);
      enter(1'b1);
      host.cmd(1'b1, 8'h80, DSR_SRC_HW, 1'b0);
      rd_chk(8'hC0);
      host.cmd(1'b1, 8'h80, DSR_SRC_FW, 1'b1);
      `CHK("fw_map", 1'b0, o_fw_map)
      // Both firmware data phases, each closed by a new command
      for (int k = 0; k < 2; k++) begin
         ev(6'h01 << k);
         rd_chk(8'h90);
         ev(6'h08);
         rd_chk(8'h80);
      end
      ev(6'h0C);
      ev(6'h0C);
      rd_chk(8'h88);
      ev(6'h08);
      rd_chk(8'h80);
      host.cmd(1'b1, 8'h84, DSR_SRC_HW, 1'b0);
      @(negedge i_sys_clk);
      `CHK("clk_busy", 1'b1, o_clk_busy)
      repeat (160) @(negedge i_sys_clk);
      `CHK("clk_sel", 1'b1, o_clk_sel)
      host.cmd(1'b1, 8'h80, DSR_SRC_OTHER, 1'b0);
      repeat (3) @(negedge i_sys_clk);
      `CHK("clk_busy", 1'b0, o_clk_busy)
      rd_chk(8'h84);
      host.cmd(1'b1, 8'hA4, DSR_SRC_HW, 1'b0);
      repeat (20) @(negedge i_sys_clk);
      `CHK("tag_active", 1'b1, o_tag_active)
      `CHK("serial_en", 1'b0, o_serial_en)
      // Entry drops the tag flag and reopens the serial side
      ev(6'h20);
      rd_chk(8'hC4);
      `CHK("serial_en", 1'b1, o_serial_en)
      // Tag-go command sets the tag flag again
      ev(6'h10);
      rd_chk(8'hE4);
      test_done();
   end
endmodule
